// >>> flash_ctrl.sv
// Purpose: Flash controller with sector protection and byte programming.
// Assumes: Driver keeps strobes off the link while cpu_stall is high.
// Notes: Erase sweeps one byte per cycle and stalls the core meanwhile.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "flash_params.svh"
module flash_ctrl (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Link to the core or debugger.
    flash_link_if.dev lk,
    // Status for the user side.
    output logic [7:0] sector_protect,
    output logic prog_mode
);
    ////////////////////////////////////////////////////////////////////////////
    flash_pkg::dev_regs_t r;
    flash_pkg::dev_regs_t n;
    logic [7:0] mem [0:`PM_WORDS-1];
    logic [7:0] pm_rdata_r;
    logic mem_we;
    logic mem_and;
    logic [`PM_AW-1:0] mem_wa;
    logic [7:0] mem_wd;
    logic stall;
    logic last;
    logic [`PG_W-1:0] pg;

    // A byte may be programmed only outside protected sectors and inside the open range.
    function automatic logic prog_ok(input flash_pkg::dev_regs_t s, input logic [`PM_AW-1:0] a);
        prog_ok = !s.prot[a[`SEC_MSB:`SEC_LSB]]
                  && (s.mass
                      || a[`PG_MSB:`PG_LSB] == s.page[`PG_W-1:0]);
    endfunction : prog_ok

    // Register file read mux; the protect register overlays the page register.
    function automatic logic [7:0] rd_mux(input flash_pkg::dev_regs_t s,
                                          input logic [`RF_AW-1:0] a);
        if (a == `FCMD_ADDR) begin
            rd_mux = {2'h0, s.st};
        end else if (a == `PAGE_ADDR) begin
            rd_mux = s.prot_sel ? s.prot : s.page;
        end else begin
            rd_mux = 8'h00;
        end
    endfunction : rd_mux

    ////////////////////////////////////////////////////////////////////////////
    // Core is idled while erasing or programming; clock keeps running.
    assign stall = (r.st == flash_pkg::ST_BUSY) || (r.st == flash_pkg::ST_ERASE);
    assign last = r.mass ? (&r.cnt) : (&r.cnt[`PG_LSB-1:0]);
    assign pg = r.page[`PG_W-1:0];
    assign lk.cpu_stall = stall;
    assign lk.rf_rdata = r.rf_rdata;
    assign lk.pm_rdata = pm_rdata_r;
    assign sector_protect = r.prot;
    assign prog_mode = (r.st == flash_pkg::ST_PROG) || (r.st == flash_pkg::ST_BUSY);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for the whole controller.
    always_comb begin
        n = r;
        mem_we = 1'b0;
        mem_and = 1'b0;
        mem_wa = r.cnt;
        mem_wd = `ERASED;
        if (lk.rf_rd) begin
            n.rf_rdata = rd_mux(r, lk.rf_addr);
        end
        case (r.st)
            flash_pkg::ST_ERASE: begin
                mem_we = 1'b1;
                n.cnt = r.cnt + `PM_AW'(1);
                if (last) begin
                    n.st = flash_pkg::ST_PROG;
                end
            end
            flash_pkg::ST_BUSY: begin
                if (r.tmr == 8'h00) begin
                    mem_we = 1'b1;
                    mem_and = 1'b1;
                    mem_wa = r.paddr;
                    mem_wd = r.pdata;
                    n.st = flash_pkg::ST_PROG;
                end else begin
                    n.tmr = r.tmr - 8'h01;
                end
            end
            flash_pkg::ST_PROG: begin
                // Stores are only accepted in program mode; refused ones leave no trace.
                if (lk.pm_wr && prog_ok(r, lk.pm_addr)) begin
                    n.st = flash_pkg::ST_BUSY;
                    n.tmr = 8'(`PROG_CYC - 1);
                    n.paddr = lk.pm_addr;
                    n.pdata = lk.pm_wdata;
                end
            end
            default: begin
            end
        endcase
        // Register writes are ignored while the core is held.
        if (lk.rf_wr && !stall) begin
            if (lk.rf_addr == `FCMD_ADDR) begin
                // Only the select code, issued from the reset state, opens the overlay.
                n.prot_sel = (lk.rf_wdata == `CMD_PROT) && (r.st == flash_pkg::ST_LOCKED);
                case (lk.rf_wdata)
                    `CMD_RESET: begin
                        n.st = flash_pkg::ST_LOCKED;
                    end
                    `CMD_PROT: begin
                        n.st = flash_pkg::ST_LOCKED;
                    end
                    `CMD_KEY1: begin
                        n.st = (r.st == flash_pkg::ST_LOCKED) ? flash_pkg::ST_KEY1
                                                             : flash_pkg::ST_LOCKED;
                    end
                    `CMD_KEY2: begin
                        n.st = (r.st == flash_pkg::ST_KEY1) ? flash_pkg::ST_UNLOCKED
                                                           : flash_pkg::ST_LOCKED;
                    end
                    `CMD_MASS: begin
                        // Any protected sector refuses the whole mass erase.
                        if ((r.st == flash_pkg::ST_UNLOCKED || r.st == flash_pkg::ST_PROG)
                            && r.prot == `PROT_RST) begin
                            n.st = flash_pkg::ST_ERASE;
                            n.mass = 1'b1;
                            n.cnt = '0;
                        end else begin
                            n.st = flash_pkg::ST_LOCKED;
                        end
                    end
                    `CMD_PAGE: begin
                        if ((r.st == flash_pkg::ST_UNLOCKED || r.st == flash_pkg::ST_PROG)
                            && !r.prot[pg[`PG_W-1:`SEC_LSB-`PG_LSB]]) begin
                            n.st = flash_pkg::ST_ERASE;
                            n.mass = 1'b0;
                            n.cnt = {pg, {`PG_LSB{1'b0}}};
                        end else begin
                            n.st = flash_pkg::ST_LOCKED;
                        end
                    end
                    default: begin
                        n.st = flash_pkg::ST_LOCKED;
                    end
                endcase
            end else if (lk.rf_addr == `PAGE_ADDR) begin
                if (r.prot_sel) begin
                    n.prot = r.prot | lk.rf_wdata;
                end else begin
                    n.page = lk.rf_wdata;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; reset leaves every sector unprotected.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.st <= flash_pkg::ST_LOCKED;
            r.prot <= `PROT_RST;
        end else begin
            r <= n;
        end
    end

    // Array write and read port; no reset so it maps onto a memory macro.
    always_ff @(posedge aclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_and ? (mem[mem_wa] & mem_wd) : mem_wd;
        end
        if (lk.pm_rd) begin
            pm_rdata_r <= mem[lk.pm_addr];
        end
    end
endmodule : flash_ctrl
`default_nettype wire

// >>> flash_host.sv
// Purpose: AXI4-Lite front end that drives the flash link for software.
// Assumes: Single clock shared with the flash controller.
// Notes: One link operation at a time; CTRL writes while busy are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "flash_params.svh"
module flash_host (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels.
    input wire logic awvalid,
    output logic awready,
    input wire logic [3:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read channels.
    input wire logic arvalid,
    output logic arready,
    input wire logic [3:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Link to the flash controller.
    flash_link_if.host lk
);
    ////////////////////////////////////////////////////////////////////////////
    flash_pkg::host_regs_t r;
    flash_pkg::host_regs_t n;
    logic [9:0] tally [0:`PM_WORDS-1];
    logic [1:0] hits;
    logic tally_we;
    logic is_erase;

    // Per-address program count, valid only for the current erase epoch.
    // An entry never written does not match, so it counts as zero programs.
    always_comb begin
        if (tally[r.addr][9:2] == r.epoch) begin
            hits = tally[r.addr][1:0];
        end else begin
            hits = 2'h0;
        end
    end
    assign is_erase = (r.addr[`RF_AW-1:0] == `FCMD_ADDR)
                      && (r.data == `CMD_MASS || r.data == `CMD_PAGE);
    assign awready = !r.awg && !r.bvalid;
    assign wready = !r.wg && !r.bvalid;
    assign arready = !r.rvalid;
    assign bvalid = r.bvalid;
    assign bresp = r.bresp;
    assign rvalid = r.rvalid;
    assign rdata = r.rdata;
    assign rresp = `RESP_OK;
    assign lk.rf_wr = r.rf_wr;
    assign lk.rf_rd = r.rf_rd;
    assign lk.rf_addr = r.addr[`RF_AW-1:0];
    assign lk.rf_wdata = r.data;
    assign lk.pm_wr = r.pm_wr;
    assign lk.pm_rd = r.pm_rd;
    assign lk.pm_addr = r.addr;
    assign lk.pm_wdata = r.data;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave and link sequencer.
    always_comb begin
        n = r;
        tally_we = 1'b0;
        n.rf_wr = 1'b0;
        n.rf_rd = 1'b0;
        n.pm_wr = 1'b0;
        n.pm_rd = 1'b0;
        if (awvalid && awready) begin
            n.awg = 1'b1;
            n.wa = awaddr;
        end
        if (wvalid && wready) begin
            n.wg = 1'b1;
            n.wd = wdata[15:0];
            n.ws = wstrb[0];
        end
        if (r.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        // The write acts once both halves are in; the response follows.
        if (r.awg && r.wg) begin
            n.awg = 1'b0;
            n.wg = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `RESP_OK;
            case (r.wa)
                `A_ADDR: begin
                    if (r.ws) n.addr = r.wd[`PM_AW-1:0];
                end
                `A_DATA: begin
                    if (r.ws) n.data = r.wd[7:0];
                end
                `A_CTRL: begin
                    if (r.ws && r.st == flash_pkg::H_IDLE) begin
                        n.op = flash_pkg::host_op_t'(r.wd[1:0]);
                        n.st = flash_pkg::H_WAIT;
                        n.refused = 1'b0;
                        case (flash_pkg::host_op_t'(r.wd[1:0]))
                            flash_pkg::OP_RFW: begin
                                n.rf_wr = 1'b1;
                                if (is_erase) n.epoch = r.epoch + 8'h01;
                            end
                            flash_pkg::OP_RFR: n.rf_rd = 1'b1;
                            flash_pkg::OP_PMW: begin
                                // A third program of one byte before an erase is held back.
                                if (hits < `PROG_TRIES) begin
                                    n.pm_wr = 1'b1;
                                    tally_we = 1'b1;
                                end else begin
                                    n.refused = 1'b1;
                                    n.st = flash_pkg::H_IDLE;
                                end
                            end
                            default: n.pm_rd = 1'b1;
                        endcase
                    end
                end
                default: n.bresp = `RESP_SLV;
            endcase
        end
        // Wait until read data has landed and the core is released, then keep the result.
        if (r.st == flash_pkg::H_WAIT && !r.pm_wr && !r.rf_wr && !r.pm_rd && !r.rf_rd
            && !lk.cpu_stall) begin
            n.st = flash_pkg::H_IDLE;
            n.rslt = (r.op == flash_pkg::OP_PMR) ? lk.pm_rdata : lk.rf_rdata;
        end
        if (r.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            n.rvalid = 1'b1;
            case (araddr)
                `A_ADDR: n.rdata = {19'h0, r.addr};
                `A_DATA: n.rdata = {24'h0, r.data};
                `A_STAT: n.rdata = {21'h0, r.refused, lk.cpu_stall,
                                    r.st == flash_pkg::H_WAIT, r.rslt};
                default: n.rdata = 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.st <= flash_pkg::H_IDLE;
        end else begin
            r <= n;
        end
    end

    // Program tally; stale epochs read as zero, so no clear sweep is needed.
    always_ff @(posedge aclk) begin
        if (tally_we) begin
            tally[r.addr] <= {r.epoch, hits + 2'h1};
        end
    end
endmodule : flash_host
`default_nettype wire

// >>> flash_link_chk.sv
// Purpose: Assertions on the link between the flash host and the flash controller.
// Assumes: One clock domain; link strobes are single-cycle pulses.
// Notes: A shadow of the overlay select, protect bits and stall run length is kept here.
`timescale 1ns/1ps
`default_nettype none
module flash_link_chk (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Register file side of the link.
    input wire logic rf_wr,
    input wire logic rf_rd,
    input wire logic [11:0] rf_addr,
    input wire logic [7:0] rf_wdata,
    input wire logic [7:0] rf_rdata,
    // Program memory side and stall.
    input wire logic pm_wr,
    input wire logic pm_rd,
    input wire logic cpu_stall
);
    typedef struct packed {
        logic sel;
        logic [7:0] prot;
        logic [13:0] run;
    } chk_state_t;
    chk_state_t s_r;
    chk_state_t s_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Shadow state; the select only tracks 5EH, so tests must issue it from the locked state.
    always_comb begin
        s_nxt = s_r;
        s_nxt.run = cpu_stall ? s_r.run + 14'h0001 : 14'h0000;
        if (rf_wr && rf_addr == 12'hFF8) begin
            s_nxt.sel = (rf_wdata == 8'h5E);
        end
        if (rf_wr && rf_addr == 12'hFF9 && s_r.sel) begin
            s_nxt.prot = s_r.prot | rf_wdata;
        end
    end

    // Reset empties the shadow just as it empties the protect register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // All checks run on the one clock and are quiet during reset.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_reset_no_stall: assert property ($rose(aresetn) |-> !cpu_stall)
        else $error("stall high right after reset");
    chk_prot_readback: assert property (rf_rd && rf_addr == 12'hFF9 && s_r.sel
        |=> rf_rdata == s_r.prot) else $error("protect readback differs from written bits");
    chk_cmd_onehot: assert property (rf_rd && rf_addr == 12'hFF8
        |=> rf_rdata[7:6] == 2'h0 && $onehot(rf_rdata[5:0])) else $error("bad command readback");
    // The run counter proves the stall held without a gap, so no long repetition is needed.
    chk_store_stall_len: assert property ($rose(cpu_stall) && $past(pm_wr)
        |-> ##9 (cpu_stall && s_r.run == 14'h0009) ##1 !cpu_stall)
        else $error("store stall length wrong");
    chk_stall_has_cause: assert property ($rose(cpu_stall)
        |-> $past(pm_wr) || ($past(rf_wr) && $past(rf_addr) == 12'hFF8))
        else $error("stall without store or command");
    chk_stall_run_span: assert property ($fell(cpu_stall)
        |-> s_r.run inside {14'h000A, 14'h0200, 14'h2000}) else $error("stall run length wrong");
    chk_quiet_in_stall: assert property (cpu_stall
        |-> !(rf_wr || rf_rd || pm_wr || pm_rd)) else $error("strobe during stall");
    chk_rdata_held: assert property (!rf_rd |=> $stable(rf_rdata))
        else $error("register read data changed without a read");
    chk_store_pulse: assert property (pm_wr |=> !pm_wr)
        else $error("store strobe longer than one cycle");

    // Main scenarios reached.
    cov_store: cover property ($rose(cpu_stall) && $past(pm_wr));
    cov_mass_erase: cover property ($fell(cpu_stall) && s_r.run == 14'h2000);
    cov_page_erase: cover property ($fell(cpu_stall) && s_r.run == 14'h0200);
    cov_prot_read: cover property (rf_rd && rf_addr == 12'hFF9 && s_r.sel);
endmodule : flash_link_chk
`default_nettype wire

// >>> flash_link_if.sv
// Purpose: Link between the flash controller and the party that drives it.
// Assumes: Both ends run on the same aclk.
// Notes: Strobes are one-cycle pulses; read data returns one cycle later.
`timescale 1ns/1ps
`default_nettype none
`include "flash_params.svh"
interface flash_link_if;
    logic rf_wr;
    logic rf_rd;
    logic [`RF_AW-1:0] rf_addr;
    logic [7:0] rf_wdata;
    logic [7:0] rf_rdata;
    logic pm_wr;
    logic pm_rd;
    logic [`PM_AW-1:0] pm_addr;
    logic [7:0] pm_wdata;
    logic [7:0] pm_rdata;
    logic cpu_stall;
    modport dev (input rf_wr, rf_rd, rf_addr, rf_wdata, pm_wr, pm_rd, pm_addr, pm_wdata,
                 output rf_rdata, pm_rdata, cpu_stall);
    modport host (output rf_wr, rf_rd, rf_addr, rf_wdata, pm_wr, pm_rd, pm_addr, pm_wdata,
                  input rf_rdata, pm_rdata, cpu_stall);
endinterface : flash_link_if
`default_nettype wire

// >>> flash_params.svh
// Purpose: Shared constants for the flash protect and byte program link.
// Assumes: 250 MHz aclk, 8 KB program memory, 512-byte pages, 1 KB sectors.
// Notes: Included by the package and both ends.
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH
// Register file locations on the device link.
`define RF_AW 12
`define FCMD_ADDR 12'hFF8
`define PAGE_ADDR 12'hFF9
// Flash command codes.
`define CMD_RESET 8'h00
`define CMD_PROT 8'h5E
`define CMD_KEY1 8'h73
`define CMD_KEY2 8'h8C
`define CMD_MASS 8'h63
`define CMD_PAGE 8'h95
// Memory geometry and field positions.
`define PM_AW 13
`define PM_WORDS 8192
`define SEC_MSB 12
`define SEC_LSB 10
`define PG_MSB 12
`define PG_LSB 9
`define PG_W 4
`define ERASED 8'hFF
`define PROT_RST 8'h00
`define PROG_TRIES 2'h2
// Programming time per byte and the derived cycle count (rounded up).
`define CLK_NS 4
`define PROG_TIME_NS 40
`define PROG_CYC ((`PROG_TIME_NS + `CLK_NS - 1) / `CLK_NS)
// Host register offsets on the AXI4-Lite side.
`define A_ADDR 4'h0
`define A_DATA 4'h4
`define A_CTRL 4'h8
`define A_STAT 4'hC
`define RESP_OK 2'h0
`define RESP_SLV 2'h2
`endif

// >>> flash_pkg.sv
// Purpose: Types shared by both ends of the flash link.
// Assumes: Constants come from flash_params.svh.
// Notes: State machines use one-hot codes.
`include "flash_params.svh"
package flash_pkg;
    typedef enum logic [5:0] {
        ST_LOCKED = 6'h01,
        ST_KEY1 = 6'h02,
        ST_UNLOCKED = 6'h04,
        ST_ERASE = 6'h08,
        ST_PROG = 6'h10,
        ST_BUSY = 6'h20
    } dev_state_t;
    typedef struct packed {
        dev_state_t st;
        logic [7:0] prot;
        logic [7:0] page;
        logic prot_sel;
        logic mass;
        logic [`PM_AW-1:0] cnt;
        logic [7:0] tmr;
        logic [`PM_AW-1:0] paddr;
        logic [7:0] pdata;
        logic [7:0] rf_rdata;
    } dev_regs_t;
    typedef enum logic [1:0] {
        H_IDLE = 2'h1,
        H_WAIT = 2'h2
    } host_state_t;
    typedef enum logic [1:0] {
        OP_RFW = 2'h0,
        OP_RFR = 2'h1,
        OP_PMW = 2'h2,
        OP_PMR = 2'h3
    } host_op_t;
    typedef struct packed {
        host_state_t st;
        host_op_t op;
        logic awg;
        logic wg;
        logic [3:0] wa;
        logic [15:0] wd;
        logic ws;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [`PM_AW-1:0] addr;
        logic [7:0] data;
        logic [7:0] rslt;
        logic refused;
        logic [7:0] epoch;
        logic rf_wr;
        logic rf_rd;
        logic pm_wr;
        logic pm_rd;
    } host_regs_t;
endpackage : flash_pkg

// >>> tb.sv
// Purpose: Self-checking bench for the flash host and controller joined by their link.
// Assumes: Software view through AXI4-Lite; link ops polled through the status word.
// Notes: Protect bits only clear by reset, so protection is tested after programming.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, prog_mode;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, st;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] sector_protect;
    int error_cnt;
    int comparisons;

    ////////////////////////////////////////////////////////////////////////////////
    // The two ends face each other across the link; the checker watches it.
    flash_link_if lk ();
    flash_ctrl i_flash_ctrl (.aclk(aclk), .aresetn(aresetn), .lk(lk),
        .sector_protect(sector_protect), .prog_mode(prog_mode));
    flash_host i_flash_host (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .lk(lk));
    flash_link_chk i_flash_link_chk (.aclk(aclk), .aresetn(aresetn), .rf_wr(lk.rf_wr),
        .rf_rd(lk.rf_rd), .rf_addr(lk.rf_addr), .rf_wdata(lk.rf_wdata),
        .rf_rdata(lk.rf_rdata), .pm_wr(lk.pm_wr), .pm_rd(lk.pm_rd), .cpu_stall(lk.cpu_stall));

    // Free-running 4 ns clock.
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run, shared with the watchdog.
    task automatic close_out();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", n, exp, seen);
        end
    endtask : chk

    // Handshakes are judged just before the edge, so readies that move at the edge never race.
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_h, w_h, b_h;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_h = awvalid && awready;
            w_h = wvalid && wready;
            b_h = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            if (aw_h) awvalid <= 1'b0;
            if (w_h) wvalid <= 1'b0;
        end while (!b_h);
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        logic ar_h, r_h;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ar_h = arvalid && arready;
            r_h = rvalid && rready;
            d = rdata;
            @(posedge aclk);
            if (ar_h) arvalid <= 1'b0;
        end while (!r_h);
        rready <= 1'b0;
    endtask : axi_rd

    // One link operation, then poll until neither busy nor stall is set.
    task automatic op(input logic [1:0] k, input logic [12:0] a, input logic [7:0] d);
        axi_wr(4'h0, {19'h00000, a}, resp);
        axi_wr(4'h4, {24'h000000, d}, resp);
        axi_wr(4'h8, {30'h00000000, k}, resp);
        do axi_rd(4'hC, st); while (st[9:8] !== 2'h0);
    endtask : op

    task automatic rd(input logic [1:0] k, input logic [12:0] a, input logic [7:0] e,
                      input string n);
        op(k, a, 8'h00);
        chk(n, st[7:0], e);
    endtask : rd

    task automatic keys(input logic [7:0] c);
        op(2'h0, 13'h0FF8, 8'h73);
        op(2'h0, 13'h0FF8, 8'h8C);
        op(2'h0, 13'h0FF8, c);
    endtask : keys

    ////////////////////////////////////////////////////////////////////////////////
    // Cuts a hang short; the whole run needs well under a third of this.
    initial begin
        repeat (60000) @(posedge aclk);
        error_cnt++;
        close_out();
    end

    // Main sequence.
    initial begin
        error_cnt = 0;
        comparisons = 0;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = {8'h00, 32'h00000000, 4'hF};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(2'h1, 13'h0FF8, 8'h01, "command after reset");
        chk("protect after reset", sector_protect, 8'h00);
        axi_wr(4'h2, 32'h00000000, resp);
        chk("unmapped bresp", {6'h00, resp}, 8'h02);
        axi_rd(4'h6, st);
        chk("unmapped read", st[7:0], 8'h00);
        chk("read response", {6'h00, rresp}, 8'h00);
        // Mass erase opens every address; stores only clear bits.
        keys(8'h63);
        @(negedge aclk);
        chk("mode after mass erase", {7'h00, prog_mode}, 8'h01);
        rd(2'h3, 13'h0100, 8'hFF, "erased byte");
        op(2'h2, 13'h0100, 8'hA5);
        rd(2'h3, 13'h0100, 8'hA5, "first store");
        op(2'h2, 13'h0100, 8'h5A);
        rd(2'h3, 13'h0100, 8'h00, "second store ands");
        op(2'h2, 13'h1FFF, 8'h3C);
        rd(2'h3, 13'h1FFF, 8'h3C, "store at top");
        // A non-erase command locks; a later store is dropped.
        op(2'h0, 13'h0FF8, 8'h11);
        rd(2'h1, 13'h0FF8, 8'h01, "locked after command");
        op(2'h2, 13'h1FFF, 8'h00);
        rd(2'h3, 13'h1FFF, 8'h3C, "store while locked");
        // Page erase of page 2 leaves other pages alone and confines stores.
        op(2'h0, 13'h0FF9, 8'h02);
        keys(8'h95);
        rd(2'h3, 13'h0400, 8'hFF, "page erased");
        rd(2'h3, 13'h1FFF, 8'h3C, "other page kept");
        op(2'h2, 13'h0600, 8'h00);
        rd(2'h3, 13'h0600, 8'hFF, "store outside page");
        op(2'h2, 13'h05FF, 8'h12);
        rd(2'h3, 13'h05FF, 8'h12, "store at page end");
        op(2'h2, 13'h0500, 8'hF0);
        op(2'h2, 13'h0500, 8'h30);
        op(2'h2, 13'h0500, 8'h00);
        chk("third store refused", {7'h00, st[10]}, 8'h01);
        rd(2'h3, 13'h0500, 8'h30, "byte after refusal");
        // Protect overlay: select, set-only bits, deselect.
        op(2'h0, 13'h0FF8, 8'h00);
        @(negedge aclk);
        chk("mode after reset command", {7'h00, prog_mode}, 8'h00);
        op(2'h0, 13'h0FF8, 8'h5E);
        op(2'h0, 13'h0FF9, 8'h05);
        rd(2'h1, 13'h0FF9, 8'h05, "protect selected");
        op(2'h0, 13'h0FF9, 8'h02);
        rd(2'h1, 13'h0FF9, 8'h07, "protect set only");
        @(negedge aclk);
        chk("protect outputs", sector_protect, 8'h07);
        op(2'h0, 13'h0FF8, 8'h00);
        rd(2'h1, 13'h0FF9, 8'h02, "page register back");
        // Erases touching a protected sector are refused.
        op(2'h0, 13'h0FF9, 8'h00);
        keys(8'h95);
        rd(2'h1, 13'h0FF8, 8'h01, "page erase refused");
        keys(8'h63);
        rd(2'h1, 13'h0FF8, 8'h01, "mass erase refused");
        // A second reset in mid-run clears protection.
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk("protect after second reset", sector_protect, 8'h00);
        rd(2'h1, 13'h0FF8, 8'h01, "command after second reset");
        rd(2'h1, 13'h0FF9, 8'h00, "page after second reset");
        close_out();
    end
endmodule : tb
`default_nettype wire
